// ### src/dsc_pkg.sv
// Constants shared by the dual asynchronous serial channel design
// Notes on behaviour
// - Each channel picks one of eight bit rates, 110 to 19200 baud, independently.
// - Channel A uses ports 0 and 1, channel B ports 2 and 3.
// - A board strap swaps status/command and data ports within each pair.
// - After any reset the first command port write is the format byte.
// - Format bits 1:0 give divide factor; value 10 means sixteen clocks per bit. The code ignores these bits and runs every value at 16x.
// - Format bits 3:2 give five, six, seven or eight data bits.
// - Format bits 7:6 give invalid, one, one and a half or two stops.
// - Later command port writes are commands driving lines, enables, clears, break, reformat.
// - Reading the command port returns the line status byte.
// - Command bits 0 and 2 also mask transmit and receive requests.
// - Status bits 5, 4, 3 latch framing, overrun and parity errors.
// - Status bit 0 means holding buffer free; bit 2 means transmitter empty.
// - Status bit 1 means a received character waits to be read.
// - Receive and transmit requests of a channel are ORed into one request.
// - Receive request only while receive enabled and a character is held.
// - With receive disabled no start bit is detected.
// - Transmit request only with transmit enabled, CTS asserted and buffer empty.
// - Transmit disabled raises no request even after the buffer is loaded.
package dsc_pkg;
	// ----------------------------------------
	// Format byte fields
	// ----------------------------------------
	localparam int FMT_DIV_LO = 0;
	localparam int FMT_LEN_LO = 2;
	localparam int FMT_PAR_EN = 4;
	localparam int FMT_PAR_EVEN = 5;
	localparam int FMT_STOP_LO = 6;
	localparam logic [1:0] DIV_X16 = 2'h2;
	// ----------------------------------------
	// Command byte fields
	// ----------------------------------------
	localparam int CMD_TX_EN = 0;
	localparam int CMD_DTR = 1;
	localparam int CMD_RX_EN = 2;
	localparam int CMD_BREAK = 3;
	localparam int CMD_ERR_CLR = 4;
	localparam int CMD_RTS = 5;
	localparam int CMD_REFORMAT = 6;
	localparam logic [7:0] CMD_RESET = 8'h00;
	// ----------------------------------------
	// Status byte fields
	// ----------------------------------------
	localparam int ST_TX_RDY = 0;
	localparam int ST_RX_AVAIL = 1;
	localparam int ST_TX_EMPTY = 2;
	localparam int ST_PAR_ERR = 3;
	localparam int ST_OVR_ERR = 4;
	localparam int ST_FRM_ERR = 5;
	localparam int ST_DSR = 7;
	// ----------------------------------------
	// Port map and rates
	// ----------------------------------------
	localparam logic [1:0] PORT_A_LO = 2'h0;
	localparam logic [1:0] PORT_B_LO = 2'h2;
	localparam int NUM_RATES = 8;
	localparam int CLK_HZ = 100000000;
	localparam int RATE_110 = 110;
	localparam int RATE_150 = 150;
	localparam int RATE_300 = 300;
	localparam int RATE_600 = 600;
	localparam int RATE_1200 = 1200;
	localparam int RATE_2400 = 2400;
	localparam int RATE_4800 = 4800;
	localparam int RATE_19200 = 19200;
	localparam int OVERSAMPLE = 16;
	// Clocks per 16x tick, rounded down
	localparam int TICK_DIV_MAX = CLK_HZ / (RATE_110 * OVERSAMPLE);
	localparam logic [7:0] BIT_TIMING_UNUSED = 8'h00;
	typedef enum logic [1:0] {DSC_TX_IDLE_T, DSC_TX_SHIFT_T, DSC_TX_STOP_T} dsc_unused_t;
endpackage

// ### src/dsc_rate_gen.sv
// Selectable 16x bit clock tick generator
`timescale 1ns/100ps
`default_nettype none
module dsc_rate_gen (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [2:0] rate_sel,
	output logic tick
);
	logic [19:0] cnt_r;
	logic [19:0] lim;

	always_comb begin
		case (rate_sel)
			3'h0: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_110 * dsc_pkg::OVERSAMPLE));
			3'h1: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_150 * dsc_pkg::OVERSAMPLE));
			3'h2: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_300 * dsc_pkg::OVERSAMPLE));
			3'h3: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_600 * dsc_pkg::OVERSAMPLE));
			3'h4: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_1200 * dsc_pkg::OVERSAMPLE));
			3'h5: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_2400 * dsc_pkg::OVERSAMPLE));
			3'h6: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_4800 * dsc_pkg::OVERSAMPLE));
			default: lim = 20'(dsc_pkg::CLK_HZ / (dsc_pkg::RATE_19200 * dsc_pkg::OVERSAMPLE));
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 20'h00000;
			tick <= 1'b0;
		end else if (cnt_r + 20'h00001 >= lim) begin
			cnt_r <= 20'h00000;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 20'h00001;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### src/dsc_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dsc_skid #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [2];
	logic rd_r;
	logic wr_r;
	logic [1:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data;
				wr_r <= ~wr_r;
			end
			if (pop) begin
				rd_r <= ~rd_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// ### src/dsc_channel_pair.sv
// Dual asynchronous serial channel with host port pair access
`timescale 1ns/100ps
`default_nettype none
module dsc_chan (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sw_reset,
	input wire logic [2:0] rate_sel,
	input wire logic cmd_wr,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic [7:0] wdata,
	output logic [7:0] status,
	output logic [7:0] rx_data,
	output logic irq,
	input wire logic rxd,
	input wire logic cts_b,
	input wire logic dsr_b,
	output logic txd,
	output logic rts_b,
	output logic dtr_b
);
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP} dsc_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} dsc_rx_t;

	logic tick;
	logic [1:0] rxd_s_r;
	logic [1:0] cts_s_r;
	logic [1:0] dsr_s_r;
	logic fmt_done_r;
	logic [7:0] fmt_r;
	logic [7:0] cmd_r;
	logic [3:0] nbits;
	logic [5:0] stop_ticks;
	logic hold_ready;
	logic buf_valid;
	logic buf_pop;
	logic [7:0] buf_data;
	dsc_tx_t tx_st_r;
	logic [7:0] tx_sh_r;
	logic [3:0] tx_bit_r;
	logic [5:0] tx_tk_r;
	logic tx_par_r;
	dsc_rx_t rx_st_r;
	logic [7:0] rx_sh_r;
	logic [3:0] rx_bit_r;
	logic [5:0] rx_tk_r;
	logic rx_par_r;
	logic rx_full_r;
	logic par_err_r;
	logic ovr_err_r;
	logic frm_err_r;
	logic rx_done;
	logic rx_bad_frm;
	logic rx_bad_par;

	// ----------------------------------------
	// Rate tick and pin synchronisers
	// ----------------------------------------
	dsc_rate_gen u_rate (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.rate_sel(rate_sel),
		.tick(tick)
	);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_s_r <= 2'h3;
			cts_s_r <= 2'h3;
			dsr_s_r <= 2'h3;
		end else begin
			rxd_s_r <= {rxd_s_r[0], rxd};
			cts_s_r <= {cts_s_r[0], cts_b};
			dsr_s_r <= {dsr_s_r[0], dsr_b};
		end
	end

	// ----------------------------------------
	// Format and command bytes
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fmt_done_r <= 1'b0;
			fmt_r <= 8'h4E;
			cmd_r <= dsc_pkg::CMD_RESET;
		end else if (sw_reset) begin
			fmt_done_r <= 1'b0;
			cmd_r <= dsc_pkg::CMD_RESET;
		end else if (cmd_wr && !fmt_done_r) begin
			fmt_r <= wdata;
			fmt_done_r <= 1'b1;
		end else if (cmd_wr) begin
			cmd_r <= wdata;
			if (wdata[dsc_pkg::CMD_REFORMAT]) begin
				fmt_done_r <= 1'b0;
				cmd_r <= dsc_pkg::CMD_RESET;
			end
		end
	end

	// Only the 16x factor is meaningful with this tick; others run as 16x
	assign nbits = 4'h5 + {2'h0, fmt_r[dsc_pkg::FMT_LEN_LO +: 2]};
	// Invalid stop code falls back to one stop bit
	always_comb begin
		case (fmt_r[dsc_pkg::FMT_STOP_LO +: 2])
			2'h2: stop_ticks = 6'd24;
			2'h3: stop_ticks = 6'd32;
			default: stop_ticks = 6'd16;
		endcase
	end
	assign rts_b = ~cmd_r[dsc_pkg::CMD_RTS];
	assign dtr_b = ~cmd_r[dsc_pkg::CMD_DTR];

	// ----------------------------------------
	// Transmit path: buffer, then shifter
	// ----------------------------------------
	dsc_skid #(.W(8)) u_txbuf (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.in_valid(data_wr),
		.in_ready(hold_ready),
		.in_data(wdata),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data(buf_data)
	);

	// Shifting runs once loaded even if enable drops later
	assign buf_pop = (tx_st_r == TX_IDLE) && buf_valid && cmd_r[dsc_pkg::CMD_TX_EN]
		&& !cts_s_r[1];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 8'hFF;
			tx_bit_r <= 4'h0;
			tx_tk_r <= 6'h00;
			tx_par_r <= 1'b0;
			txd <= 1'b1;
		end else begin
			case (tx_st_r)
				TX_IDLE: begin
					txd <= ~cmd_r[dsc_pkg::CMD_BREAK];
					if (buf_pop) begin
						tx_sh_r <= buf_data;
						tx_par_r <= ^buf_data[4:0] ^ ~fmt_r[dsc_pkg::FMT_PAR_EVEN];
						tx_bit_r <= 4'h0;
						tx_tk_r <= 6'h00;
						txd <= 1'b0;
						tx_st_r <= TX_DATA;
					end
				end
				TX_DATA: if (tick) begin
					tx_tk_r <= tx_tk_r + 6'h01;
					if (tx_tk_r == 6'd15) begin
						tx_tk_r <= 6'h00;
						txd <= tx_sh_r[0];
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						if (tx_bit_r >= 4'h5 && tx_bit_r < nbits)
							tx_par_r <= tx_par_r ^ tx_sh_r[0];
						tx_bit_r <= tx_bit_r + 4'h1;
						if (tx_bit_r == nbits) begin
							txd <= fmt_r[dsc_pkg::FMT_PAR_EN] ? tx_par_r : 1'b1;
							tx_st_r <= fmt_r[dsc_pkg::FMT_PAR_EN] ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: if (tick) begin
					tx_tk_r <= tx_tk_r + 6'h01;
					if (tx_tk_r == 6'd15) begin
						tx_tk_r <= 6'h00;
						txd <= 1'b1;
						tx_st_r <= TX_STOP;
					end
				end
				TX_STOP: if (tick) begin
					tx_tk_r <= tx_tk_r + 6'h01;
					if (tx_tk_r == stop_ticks - 6'h01) begin
						tx_st_r <= TX_IDLE;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	assign rx_done = tick && (rx_st_r == RX_STOP) && (rx_tk_r == 6'd23);
	assign rx_bad_frm = !rxd_s_r[1];
	// Good frame folds to 0 for even, 1 for odd
	assign rx_bad_par = fmt_r[dsc_pkg::FMT_PAR_EN]
		&& (rx_par_r == fmt_r[dsc_pkg::FMT_PAR_EVEN]);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_r <= RX_IDLE;
			rx_sh_r <= 8'h00;
			rx_bit_r <= 4'h0;
			rx_tk_r <= 6'h00;
			rx_par_r <= 1'b0;
		end else if (!cmd_r[dsc_pkg::CMD_RX_EN]) begin
			rx_st_r <= RX_IDLE;
		end else if (tick) begin
			rx_tk_r <= rx_tk_r + 6'h01;
			case (rx_st_r)
				RX_IDLE: begin
					rx_tk_r <= 6'h00;
					// Count from zero, so the first sample lands mid bit 0
					if (!rxd_s_r[1]) begin
						rx_st_r <= RX_DATA;
						rx_bit_r <= 4'h0;
						rx_sh_r <= 8'h00;
						rx_par_r <= 1'b0;
					end
				end
				RX_DATA: if (rx_tk_r == 6'd23) begin
					rx_tk_r <= 6'd8;
					rx_sh_r[rx_bit_r[2:0]] <= rxd_s_r[1];
					rx_par_r <= rx_par_r ^ rxd_s_r[1];
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r + 4'h1 == nbits)
						rx_st_r <= fmt_r[dsc_pkg::FMT_PAR_EN] ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_tk_r == 6'd23) begin
					rx_tk_r <= 6'd8;
					rx_par_r <= rx_par_r ^ rxd_s_r[1];
					rx_st_r <= RX_STOP;
				end
				RX_STOP: if (rx_tk_r == 6'd23) begin
					rx_st_r <= RX_IDLE;
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// Stop sampled 16 ticks after the last bit sample, mid stop bit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_full_r <= 1'b0;
			rx_data <= 8'h00;
			par_err_r <= 1'b0;
			ovr_err_r <= 1'b0;
			frm_err_r <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_full_r <= 1'b1;
				rx_data <= rx_sh_r;
			end else if (data_rd) begin
				rx_full_r <= 1'b0;
			end
			// Set wins over clear for each error flag
			if (rx_done && rx_full_r && !data_rd)
				ovr_err_r <= 1'b1;
			else if (cmd_wr && fmt_done_r && wdata[dsc_pkg::CMD_ERR_CLR])
				ovr_err_r <= 1'b0;
			if (rx_done && rx_bad_frm)
				frm_err_r <= 1'b1;
			else if (cmd_wr && fmt_done_r && wdata[dsc_pkg::CMD_ERR_CLR])
				frm_err_r <= 1'b0;
			if (rx_done && rx_bad_par)
				par_err_r <= 1'b1;
			else if (cmd_wr && fmt_done_r && wdata[dsc_pkg::CMD_ERR_CLR])
				par_err_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status and request
	// ----------------------------------------
	always_comb begin
		status = 8'h00;
		status[dsc_pkg::ST_TX_RDY] = hold_ready;
		status[dsc_pkg::ST_RX_AVAIL] = rx_full_r;
		status[dsc_pkg::ST_TX_EMPTY] = !buf_valid && (tx_st_r == TX_IDLE);
		status[dsc_pkg::ST_PAR_ERR] = par_err_r;
		status[dsc_pkg::ST_OVR_ERR] = ovr_err_r;
		status[dsc_pkg::ST_FRM_ERR] = frm_err_r;
		status[dsc_pkg::ST_DSR] = !dsr_s_r[1];
	end

	// Waits for the shifter too, so a brief enable pulse raises no request
	assign irq = (cmd_r[dsc_pkg::CMD_RX_EN] && rx_full_r)
		|| (cmd_r[dsc_pkg::CMD_TX_EN] && !cts_s_r[1] && !buf_valid
		&& (tx_st_r == TX_IDLE));
endmodule

module dsc_channel_pair (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic data_first,
	input wire logic [1:0] sw_reset,
	input wire logic [2:0] chan_a_bit_clock,
	input wire logic [2:0] chan_b_bit_clock,
	input wire logic [1:0] rxd,
	input wire logic [1:0] cts_b,
	input wire logic [1:0] dsr_b,
	output logic [1:0] txd,
	output logic [1:0] rts_b,
	output logic [1:0] dtr_b,
	output logic [1:0] rx_char_waiting_irq
);
	logic [1:0] cmd_wr;
	logic [1:0] data_wr;
	logic [1:0] data_rd;
	logic [7:0] st [2];
	logic [7:0] rd [2];
	logic [1:0] irq;
	logic [1:0] txd_w;
	logic [1:0] rts_w;
	logic [1:0] dtr_w;
	logic is_data;
	logic ch;

	assign ch = host_addr[1];
	assign is_data = host_addr[0] ^ data_first;
	assign cmd_wr = {ch & host_wr & !is_data, !ch & host_wr & !is_data};
	assign data_wr = {ch & host_wr & is_data, !ch & host_wr & is_data};
	assign data_rd = {ch & host_rd & is_data, !ch & host_rd & is_data};

	for (genvar i = 0; i < 2; i++) begin : g_ch
		dsc_chan u_ch (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.sw_reset(sw_reset[i]),
			.rate_sel(i == 0 ? chan_a_bit_clock : chan_b_bit_clock),
			.cmd_wr(cmd_wr[i]),
			.data_wr(data_wr[i]),
			.data_rd(data_rd[i]),
			.wdata(host_wdata),
			.status(st[i]),
			.rx_data(rd[i]),
			.irq(irq[i]),
			.rxd(rxd[i]),
			.cts_b(cts_b[i]),
			.dsr_b(dsr_b[i]),
			.txd(txd_w[i]),
			.rts_b(rts_w[i]),
			.dtr_b(dtr_w[i])
		);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			host_rdata <= 8'h00;
			txd <= 2'h3;
			rts_b <= 2'h3;
			dtr_b <= 2'h3;
			rx_char_waiting_irq <= 2'h0;
		end else begin
			host_rdata <= is_data ? rd[ch] : st[ch];
			txd <= txd_w;
			rts_b <= rts_w;
			dtr_b <= dtr_w;
			rx_char_waiting_irq <= irq;
		end
	end
endmodule
`default_nettype wire

// ### dv/dsc_channel_pair_monitor.sv
// Checker on the dual serial channel ports
`timescale 1ns/100ps
`default_nettype none
module dsc_channel_pair_monitor (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [1:0] host_addr,
	input wire logic host_rd,
	input wire logic [7:0] host_rdata,
	input wire logic data_first,
	input wire logic [1:0] sw_reset,
	input wire logic [1:0] dsr_b,
	input wire logic [1:0] txd,
	input wire logic [1:0] rts_b,
	input wire logic [1:0] dtr_b,
	input wire logic [1:0] rx_char_waiting_irq
);
	// ----------------
	// Status port reads, reset and soft reset checks
	// ----------------
	logic st_rd;
	assign st_rd = host_rd && (host_addr[0] == data_first);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_reset_idle;
		$rose(rst_b) |-> txd == 2'h3 && rts_b == 2'h3 && dtr_b == 2'h3
			&& rx_char_waiting_irq == 2'h0;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("Lines not idle after reset");
	property p_bit6_zero;
		st_rd |=> !host_rdata[6];
	endproperty
	a_bit6_zero: assert property (p_bit6_zero)
		else $error("Status bit 6 set");
	// Two sync stages, so the level must settle before the read
	property p_dsr_level;
		(!dsr_b[0])[*4] ##0 (st_rd && !host_addr[1]) |=> host_rdata[7];
	endproperty
	a_dsr_level: assert property (p_dsr_level)
		else $error("Status bit 7 misses DSR");
	property p_empty_ready;
		st_rd |=> !host_rdata[2] || host_rdata[0];
	endproperty
	a_empty_ready: assert property (p_empty_ready)
		else $error("Empty without ready");
	property p_read_clears;
		host_rd && host_addr[0] != data_first ##2 st_rd
			&& host_addr[1] == $past(host_addr[1], 2) |=> !host_rdata[1];
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("Data read left bit 1 set");
	property p_swr_lines_a;
		sw_reset[0] |-> ##[1:4] (rts_b[0] && dtr_b[0]);
	endproperty
	a_swr_lines_a: assert property (p_swr_lines_a)
		else $error("Soft reset kept lines A");
	property p_swr_lines_b;
		sw_reset[1] |=> ##[0:3] (rts_b[1] && dtr_b[1]);
	endproperty
	a_swr_lines_b: assert property (p_swr_lines_b)
		else $error("Soft reset kept lines B");
	property p_swr_irq;
		sw_reset[0] |-> ##[1:4] !rx_char_waiting_irq[0];
	endproperty
	a_swr_irq: assert property (p_swr_irq)
		else $error("Request kept after soft reset");
endmodule
`default_nettype wire

// ### dv/dsc_modem_model.sv
// Line-side model: sends characters and captures one transmitted frame
`timescale 1ns/100ps
`default_nettype none
module dsc_modem_model #(
	parameter int BIT_CLKS = 5200,
	parameter int NCAP = 8
) (
	input wire logic sys_clk,
	input wire logic [1:0] txd,
	output logic [1:0] rxd,
	output logic [7:0] cap,
	output logic cap_done
);
	initial begin
		rxd = 2'h3;
		cap = 8'h00;
		cap_done = 1'b0;
	end
	// Same frame on both lines, so a deaf channel can be compared
	task automatic send_char(input logic [7:0] ch, input int nbits);
		@(posedge sys_clk);
		rxd <= 2'h0;
		repeat (BIT_CLKS) @(posedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			rxd <= {2{ch[i]}};
			repeat (BIT_CLKS) @(posedge sys_clk);
		end
		rxd <= 2'h3;
		repeat (BIT_CLKS) @(posedge sys_clk);
	endtask
	// Mid-bit sampling tolerates the tick phase of the sender
	always begin
		@(negedge txd[0]);
		repeat (BIT_CLKS / 2) @(posedge sys_clk);
		for (int i = 0; i < NCAP; i++) begin
			cap[i] = txd[0];
			repeat (BIT_CLKS) @(posedge sys_clk);
		end
		cap_done = 1'b1;
	end
endmodule
`default_nettype wire

// ### dv/dsc_channel_pair_test.sv
// Self-checking bench for the dual serial channel
`timescale 1ns/100ps
`default_nettype none
module dsc_channel_pair_test;
	localparam int BIT_CLKS = dsc_pkg::CLK_HZ
		/ (dsc_pkg::RATE_19200 * dsc_pkg::OVERSAMPLE) * dsc_pkg::OVERSAMPLE;
	localparam logic [4:0] TXC = 5'h15;
	localparam logic [7:0] RXC = 8'h0B;
	logic sys_clk, rst_b, host_wr, host_rd, data_first, cap_done, b_watch, b_irq;
	logic [1:0] host_addr, sw_reset, rxd, cts_b, dsr_b, txd, rts_b, dtr_b, irq;
	logic [2:0] rate_a, rate_b;
	logic [7:0] host_wdata, host_rdata, rd_val, cap;
	int mismatches, num_checks;
	dsc_channel_pair dut (.sys_clk(sys_clk), .rst_b(rst_b), .host_addr(host_addr),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .data_first(data_first), .sw_reset(sw_reset),
		.chan_a_bit_clock(rate_a), .chan_b_bit_clock(rate_b), .rxd(rxd), .cts_b(cts_b),
		.dsr_b(dsr_b), .txd(txd), .rts_b(rts_b), .dtr_b(dtr_b), .rx_char_waiting_irq(irq));
	dsc_modem_model #(.BIT_CLKS(BIT_CLKS)) line (.sys_clk(sys_clk), .txd(txd),
		.rxd(rxd), .cap(cap), .cap_done(cap_done));
	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		host_wr = 1'b0;
		repeat (440) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge sys_clk);
		#1;
		host_addr = a;
		host_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		host_rd = 1'b0;
		rd_val = host_rdata;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(negedge sys_clk) begin
		if (b_watch && irq[1] === 1'b1) begin
			b_irq = 1'b1;
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (95000) @(posedge sys_clk);
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		{rst_b, host_wr, host_rd, data_first, b_watch, b_irq} = 6'h00;
		{host_addr, sw_reset, cts_b, dsr_b, host_wdata} = 16'h0000;
		rate_a = 3'h7;
		rate_b = 3'h7;
		mismatches = 0;
		num_checks = 0;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		check({txd, rts_b, dtr_b, irq}, 8'hFC, "reset lines");
		wr(2'h0, 8'h72);
		check({6'h0, rts_b[0], dtr_b[0]}, 8'h03, "format taken");
		wr(2'h0, 8'h23);
		check({5'h0, rts_b[0], dtr_b[0], irq[0]}, 8'h01, "command A");
		cts_b[0] = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		check({7'h0, irq[0]}, 8'h00, "cts gate");
		cts_b[0] = 1'b0;
		for (int i = 0; i < 2; i++) begin
			dsr_b[0] = (i == 1);
			data_first = (i == 1);
			repeat (4) @(posedge sys_clk);
			rd(i == 1 ? 2'h1 : 2'h0);
			check(rd_val & 8'hC5, i == 1 ? 8'h05 : 8'h85, "status A");
		end
		data_first = 1'b0;
		dsr_b = 2'h0;
		wr(2'h1, {3'h0, TXC});
		$display("test setup A done");
		wr(2'h2, 8'h42);
		wr(2'h2, 8'h04);
		wr(2'h3, 8'h0A);
		rd(2'h2);
		check({5'h0, irq[1], rd_val[2], txd[1]}, 8'h01, "tx held");
		b_watch = 1'b1;
		wr(2'h2, 8'h05);
		wr(2'h2, 8'h04);
		for (int n = 0; n < 12000 && txd[1] !== 1'b0; n++) @(posedge sys_clk);
		#1;
		b_watch = 1'b0;
		check({6'h0, txd[1], b_irq}, 8'h00, "silent send");
		$display("test tx pulse B done");
		line.send_char(RXC, 5);
		for (int n = 0; n < 200 && irq[1] !== 1'b1; n++) @(posedge sys_clk);
		#1;
		check({7'h0, irq[1]}, 8'h01, "rx request");
		rd(2'h2);
		check(rd_val & 8'h3A, 8'h02, "status B");
		rd(2'h3);
		check(rd_val & 8'h1F, RXC & 8'h1F, "rx char");
		rd(2'h2);
		check({6'h0, rd_val[1], irq[1]}, 8'h00, "drained");
		rd(2'h0);
		check(rd_val & 8'h02, 8'h00, "A deaf");
		for (int n = 0; n < 60000 && cap_done !== 1'b1; n++) @(posedge sys_clk);
		check(cap, {1'b1, ^TXC, TXC, 1'b0}, "tx frame");
		rd(2'h0);
		check(rd_val & 8'h05, 8'h05, "tx empty");
		$display("test frames done");
		sw_reset = 2'h3;
		@(posedge sys_clk);
		#1;
		sw_reset = 2'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		check({4'h0, rts_b, dtr_b}, 8'h0F, "soft reset");
		wr(2'h0, 8'h4E);
		check({7'h0, dtr_b[0]}, 8'h01, "format again");
		wr(2'h0, 8'h27);
		check({5'h0, rts_b[0], dtr_b[0], irq[0]}, 8'h01, "normal");
		wr(2'h0, 8'h2F);
		check({7'h0, txd[0]}, 8'h00, "break");
		wr(2'h0, 8'h40);
		check({5'h0, txd[0], rts_b[0], dtr_b[0]}, 8'h07, "reformat");
		wr(2'h0, 8'h27);
		check({7'h0, dtr_b[0]}, 8'h01, "format after reformat");
		$display("test soft reset done");
		tally_and_finish();
	end
endmodule
bind dsc_channel_pair dsc_channel_pair_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
	.host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata),
	.data_first(data_first), .sw_reset(sw_reset), .dsr_b(dsr_b), .txd(txd),
	.rts_b(rts_b), .dtr_b(dtr_b), .rx_char_waiting_irq(rx_char_waiting_irq));
`default_nettype wire
